// >>> hdl/mds_pkg.sv
// Shared constants and operation codes for the long multiply, divide
// and saturation datapath.
// Assumes a single core clock domain; no software-visible registers.
package mds_pkg;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int DIV_CYCLES = 32;
	localparam logic [1:0] SHIFT_NONE = 2'h0;
	localparam logic [1:0] SHIFT_LSL = 2'h1;
	localparam logic [1:0] SHIFT_ASR = 2'h2;
	localparam logic [4:0] OP_UMUL_LONG = 5'h00;
	localparam logic [4:0] OP_UMUL_ACC = 5'h01;
	localparam logic [4:0] OP_SMUL_LONG = 5'h02;
	localparam logic [4:0] OP_SMUL_ACC = 5'h03;
	localparam logic [4:0] OP_SIGNED_DIVIDE = 5'h04;
	localparam logic [4:0] OP_UNSIGNED_DIVIDE = 5'h05;
	localparam logic [4:0] OP_SCLAMP = 5'h06;
	localparam logic [4:0] OP_UCLAMP = 5'h07;
	localparam logic [4:0] OP_SCLAMP_H = 5'h08;
	localparam logic [4:0] OP_UCLAMP_H = 5'h09;
	localparam logic [4:0] OP_SADD = 5'h0a;
	localparam logic [4:0] OP_SSUB = 5'h0b;
	localparam logic [4:0] OP_SADD_H = 5'h0c;
	localparam logic [4:0] OP_SSUB_H = 5'h0d;
	localparam logic [4:0] OP_SADD_B = 5'h0e;
	localparam logic [4:0] OP_SSUB_B = 5'h0f;
	localparam logic SAT_FLAG_RESET = 1'b0;
	typedef enum logic [1:0] {
		DIV_IDLE,
		DIV_RUN,
		DIV_DONE
	} div_state_e;
endpackage

// >>> hdl/seq_divider.sv
// Iterative restoring divider, one quotient bit per cycle.
// Assumes operands are held by the caller only at start.
`timescale 1ns/10ps
module seq_divider
	import mds_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic is_signed,
	input wire logic [WIDTH-1:0] dividend,
	input wire logic [WIDTH-1:0] divisor,
	output logic done,
	output logic [WIDTH-1:0] quotient
);
	div_state_e state_reg;
	logic [5:0] count_reg;
	logic [WIDTH-1:0] rem_reg;
	logic [WIDTH-1:0] quo_reg;
	logic [WIDTH-1:0] dvs_reg;
	logic neg_reg;
	logic zero_reg;
	wire logic a_neg = is_signed & dividend[WIDTH-1];
	wire logic b_neg = is_signed & divisor[WIDTH-1];
	wire logic [WIDTH-1:0] a_mag = a_neg ? WIDTH'(-dividend) : dividend;
	wire logic [WIDTH-1:0] b_mag = b_neg ? WIDTH'(-divisor) : divisor;
	wire logic [WIDTH:0] trial = {rem_reg, quo_reg[WIDTH-1]};
	wire logic fits = trial >= {1'b0, dvs_reg};
	wire logic [WIDTH-1:0] rem_next = fits ? WIDTH'(trial - {1'b0, dvs_reg}) : trial[WIDTH-1:0];
	wire logic [WIDTH-1:0] quo_next = {quo_reg[WIDTH-2:0], fits};
	// Magnitude quotient rounds toward zero once the sign is restored
	wire logic [WIDTH-1:0] signed_q = neg_reg ? WIDTH'(-quo_reg) : quo_reg; // RL9

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= DIV_IDLE;
			count_reg <= 6'h00;
			rem_reg <= '0;
			quo_reg <= '0;
			dvs_reg <= '0;
			neg_reg <= 1'b0;
			zero_reg <= 1'b0;
			done <= 1'b0;
			quotient <= '0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				DIV_IDLE: begin
					if (start) begin
						rem_reg <= '0;
						quo_reg <= a_mag;
						dvs_reg <= b_mag;
						neg_reg <= a_neg ^ b_neg; // RL7
						zero_reg <= (divisor == '0);
						count_reg <= 6'(WIDTH);
						state_reg <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					rem_reg <= rem_next;
					quo_reg <= quo_next;
					count_reg <= count_reg - 6'h01;
					if (count_reg == 6'h01) begin
						state_reg <= DIV_DONE;
					end
				end
				DIV_DONE: begin
					// Divide by zero returns zero, no trap
					quotient <= zero_reg ? '0 : signed_q; // RL22
					done <= 1'b1; // RL23
					state_reg <= DIV_IDLE;
				end
				default: state_reg <= DIV_IDLE;
			endcase
		end
	end
endmodule // seq_divider

// >>> hdl/sat_lane.sv
// Saturating add or subtract for one signed lane of parameter width.
// Pure combinational; caller decides whether the clamp reaches the flag.
`timescale 1ns/10ps
module sat_lane #(
	parameter int W = 8
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic subtract,
	output logic [W-1:0] result,
	output logic clamped
);
	wire logic [W:0] ax = {a[W-1], a};
	wire logic [W:0] bx = {b[W-1], b};
	wire logic [W:0] raw = subtract ? ax - bx : ax + bx;
	wire logic over = raw[W] != raw[W-1];
	assign clamped = over;
	assign result = !over ? raw[W-1:0] :
		raw[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}}; // RL20
endmodule // sat_lane

// >>> hdl/long_mul_div_saturate_unit.sv
// Execution datapath: long multiply/accumulate, divide, clamp to bit
// position and lane-wise saturating add/subtract, with sticky flag.
// Assumes the pipeline issues one op when ready is high and holds
// dependents until result_valid; operands arrive already read.
`timescale 1ns/10ps

// Overview of operation
// RL1 - Unsigned long multiply gives 64-bit product halves
// RL2 - Unsigned accumulate adds product to register pair
// RL3 - Signed long multiply gives signed 64-bit product
// RL4 - Signed accumulate adds product to register pair
// RL5 - Multiply and saturation keep condition flags
// RL6 - Issuer uses distinct result registers, no SP/PC
// RL7 - Signed divide gives two's complement quotient
// RL8 - Unsigned divide gives unsigned quotient
// RL9 - Divide quotients truncate towards zero
// RL10 - Divides change no status flags
// RL11 - Signed clamp limits to n-bit signed range
// RL12 - Unsigned clamp limits to zero and 2^n-1
// RL13 - Clamping by a clamp op or a word add/sub sets sticky saturation flag
// RL14 - Only status write clears sticky flag
// RL15 - Clamp positions 1-32 signed, 0-31 unsigned
// RL16 - Optional shift precedes clamping
// RL17 - Unsigned clamp treats input as signed
// RL18 - Halfword clamp treats halves independently
// RL19 - Halfword positions 1-16 signed, 0-15 unsigned
// RL20 - Saturating add/sub in word, half, byte lanes
// RL21 - Byte and halfword lanes never touch flag
// RL22 - False condition writes nothing; divide-by-zero gives zero
// RL23 - Divide signals completion, stalls until valid
module long_mul_div_saturate_unit
	import mds_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [4:0] op_code,
	input wire logic cond_pass,
	input wire logic [DATA_W-1:0] first_operand,
	input wire logic [DATA_W-1:0] second_operand,
	input wire logic [DATA_W-1:0] acc_low,
	input wire logic [DATA_W-1:0] acc_high,
	input wire logic [5:0] sat_position,
	input wire logic [1:0] shift_kind,
	input wire logic [4:0] shift_amount,
	input wire logic status_write,
	input wire logic status_write_sat,
	output logic result_valid,
	output logic write_low,
	output logic write_high,
	output logic [DATA_W-1:0] result_low,
	output logic [DATA_W-1:0] result_high,
	output logic saturation_sticky_flag
);
	logic div_busy_reg;
	logic div_wr_reg;
	logic sat_reg;
	logic [DATA_W-1:0] low_reg;
	logic [DATA_W-1:0] high_reg;
	logic valid_reg;
	logic wlow_reg;
	logic whigh_reg;
	logic div_done;
	logic [DATA_W-1:0] div_quotient;

	// Clamp a signed 33-bit value to n-bit signed range
	// 33 bits so a position of 32 still leaves room for both limits
	function automatic logic [DATA_W:0] clamp_signed(input logic [DATA_W:0] v,
		input logic [5:0] n);
		logic [DATA_W:0] hi;
		logic [DATA_W:0] lo;
		hi = (33'h000000001 << (n - 6'h01)) - 33'h000000001;
		lo = ~hi;
		if ($signed(v) > $signed(hi)) begin
			clamp_signed = hi;
		end else if ($signed(v) < $signed(lo)) begin
			clamp_signed = lo;
		end else begin
			clamp_signed = v;
		end
	endfunction

	// Clamp a signed 33-bit value to n-bit unsigned range
	function automatic logic [DATA_W:0] clamp_unsigned(input logic [DATA_W:0] v,
		input logic [5:0] n);
		logic [DATA_W:0] hi;
		hi = (33'h000000001 << n) - 33'h000000001;
		if (v[DATA_W]) begin
			clamp_unsigned = '0;
		end else if (v > hi) begin
			clamp_unsigned = hi;
		end else begin
			clamp_unsigned = v;
		end
	endfunction

	// Multiply path, 64-bit product plus accumulation
	// The pair arrives on acc_high/acc_low; a back-to-back accumulate
	// relies on the caller forwarding the previous result
	wire logic mul_signed = (op_code == OP_SMUL_LONG) || (op_code == OP_SMUL_ACC);
	wire logic mul_acc = (op_code == OP_UMUL_ACC) || (op_code == OP_SMUL_ACC);
	wire logic [2*DATA_W-1:0] prod_u = first_operand * second_operand; // RL1
	wire logic signed [2*DATA_W-1:0] prod_s =
		$signed(first_operand) * $signed(second_operand); // RL3
	wire logic [2*DATA_W-1:0] prod = mul_signed ? prod_s : prod_u;
	// Two's complement sum is the same for signed and unsigned pairs
	wire logic [2*DATA_W-1:0] mul_sum =
		mul_acc ? prod + {acc_high, acc_low} : prod; // RL2 RL4

	// Pre-shift for word clamp; sign kept for unsigned clamp too
	wire logic [DATA_W:0] sext = {first_operand[DATA_W-1], first_operand}; // RL17
	wire logic [4:0] asr_amt = (shift_amount == 5'h00) ? 5'h01 : shift_amount;
	// Shift result is a 32-bit word, as the core's shifter gives it
	wire logic [DATA_W-1:0] lsl_word = DATA_W'(first_operand << shift_amount);
	wire logic [DATA_W:0] asr_word = $signed(sext) >>> asr_amt;
	wire logic [DATA_W:0] shifted =
		(shift_kind == SHIFT_ASR) ? asr_word :
		(shift_kind == SHIFT_LSL) ? {lsl_word[DATA_W-1], lsl_word}
			: sext; // RL16
	wire logic [DATA_W:0] shifted_s = {shifted[DATA_W-1], shifted[DATA_W-1:0]};
	// Out-of-range positions are limited to the legal window
	wire logic [5:0] n_word_s = (sat_position == 6'h00) ? 6'h01 :
		(sat_position > 6'h20) ? 6'h20 : sat_position; // RL15
	wire logic [5:0] n_word_u = (sat_position > 6'h1f) ? 6'h1f : sat_position; // RL15
	wire logic [5:0] n_half_s = (sat_position == 6'h00) ? 6'h01 :
		(sat_position > 6'h10) ? 6'h10 : sat_position; // RL19
	wire logic [5:0] n_half_u = (sat_position > 6'h0f) ? 6'h0f : sat_position; // RL19
	wire logic [DATA_W:0] word_sc = clamp_signed(shifted_s, n_word_s); // RL11
	wire logic [DATA_W:0] word_uc = clamp_unsigned(shifted_s, n_word_u); // RL12
	wire logic [DATA_W:0] hi_in = {{(HALF_W+1){first_operand[DATA_W-1]}},
		first_operand[DATA_W-1:HALF_W]};
	wire logic [DATA_W:0] lo_in = {{(HALF_W+1){first_operand[HALF_W-1]}},
		first_operand[HALF_W-1:0]};
	wire logic [DATA_W:0] hi_sc = clamp_signed(hi_in, n_half_s);
	wire logic [DATA_W:0] lo_sc = clamp_signed(lo_in, n_half_s);
	wire logic [DATA_W:0] hi_uc = clamp_unsigned(hi_in, n_half_u);
	wire logic [DATA_W:0] lo_uc = clamp_unsigned(lo_in, n_half_u);
	wire logic [DATA_W-1:0] half_s = {hi_sc[HALF_W-1:0], lo_sc[HALF_W-1:0]}; // RL18
	wire logic [DATA_W-1:0] half_u = {hi_uc[HALF_W-1:0], lo_uc[HALF_W-1:0]}; // RL18

	// Lane-wise saturating add/subtract
	wire logic lane_sub = (op_code == OP_SSUB) || (op_code == OP_SSUB_H) ||
		(op_code == OP_SSUB_B);
	logic [DATA_W-1:0] word_res;
	logic word_clamp;
	wire logic [DATA_W-1:0] halves_res;
	wire logic [DATA_W-1:0] bytes_res;
	// Each lane adds one bit wider; differing top bits mean overflow

	sat_lane #(.W(DATA_W)) u_word (
		.a(first_operand),
		.b(second_operand),
		.subtract(lane_sub),
		.result(word_res),
		.clamped(word_clamp)
	);

	genvar gi;
	generate
		for (gi = 0; gi < DATA_W / HALF_W; gi++) begin : g_half
			sat_lane #(.W(HALF_W)) u_half (
				.a(first_operand[gi*HALF_W +: HALF_W]),
				.b(second_operand[gi*HALF_W +: HALF_W]),
				.subtract(lane_sub),
				.result(halves_res[gi*HALF_W +: HALF_W]),
				.clamped()
			);
		end
		for (gi = 0; gi < DATA_W / BYTE_W; gi++) begin : g_byte
			sat_lane #(.W(BYTE_W)) u_byte (
				.a(first_operand[gi*BYTE_W +: BYTE_W]),
				.b(second_operand[gi*BYTE_W +: BYTE_W]),
				.subtract(lane_sub),
				.result(bytes_res[gi*BYTE_W +: BYTE_W]),
				.clamped()
			);
		end
	endgenerate

	// Result and clamp selection per op
	logic [DATA_W-1:0] sel_low;
	logic [DATA_W-1:0] sel_high;
	logic sel_two;
	logic sel_clamp;
	always_comb begin
		sel_low = '0;
		sel_high = '0;
		sel_two = 1'b0;
		sel_clamp = 1'b0;
		case (op_code)
			OP_UMUL_LONG, OP_UMUL_ACC, OP_SMUL_LONG, OP_SMUL_ACC: begin
				sel_low = mul_sum[DATA_W-1:0];
				sel_high = mul_sum[2*DATA_W-1:DATA_W];
				sel_two = 1'b1;
			end
			OP_SCLAMP: begin
				sel_low = word_sc[DATA_W-1:0];
				sel_clamp = word_sc != shifted_s; // RL13
			end
			OP_UCLAMP: begin
				sel_low = word_uc[DATA_W-1:0];
				sel_clamp = word_uc != shifted_s; // RL13
			end
			OP_SCLAMP_H: begin
				sel_low = half_s;
				sel_clamp = (hi_sc != hi_in) || (lo_sc != lo_in); // RL13
			end
			OP_UCLAMP_H: begin
				sel_low = half_u;
				sel_clamp = (hi_uc != hi_in) || (lo_uc != lo_in); // RL13
			end
			OP_SADD, OP_SSUB: begin
				sel_low = word_res;
				sel_clamp = word_clamp; // RL13
			end
			// Narrow lanes clamp silently by design
			OP_SADD_H, OP_SSUB_H: sel_low = halves_res; // RL21
			OP_SADD_B, OP_SSUB_B: sel_low = bytes_res; // RL21
			default: sel_low = '0;
		endcase
	end

	wire logic is_div = (op_code == OP_SIGNED_DIVIDE) || (op_code == OP_UNSIGNED_DIVIDE);
	wire logic accept = issue_valid && issue_ready;
	wire logic div_start = accept && is_div;
	wire logic single_take = accept && !is_div;
	// Divide keeps the flag untouched; only clamping ops may set it
	wire logic flag_set = single_take && cond_pass && sel_clamp; // RL10 RL22
	// A lost set would hide a clamp from software; a lost clear can be redone
	// Set beats a same-cycle clear
	wire logic sat_next = flag_set ? 1'b1 :
		status_write ? status_write_sat : sat_reg; // RL14

	// Divider latches operands at start; the caller may change them after
	seq_divider #(.WIDTH(DATA_W)) u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(div_start),
		.is_signed(op_code == OP_SIGNED_DIVIDE), // RL7 RL8
		.dividend(first_operand),
		.divisor(second_operand),
		.done(div_done),
		.quotient(div_quotient)
	);

	// Stall issue while a divide is in flight
	// One divide at a time: a single write port traded for throughput
	assign issue_ready = !div_busy_reg; // RL23

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_busy_reg <= 1'b0;
			div_wr_reg <= 1'b0;
		end else if (div_start) begin
			div_busy_reg <= 1'b1;
			div_wr_reg <= cond_pass;
		end else if (div_done) begin
			div_busy_reg <= 1'b0;
		end
	end

	// Divide completion owns the write port; issue is stalled then,
	// so no single-cycle result can collide with the quotient
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			valid_reg <= 1'b0;
			wlow_reg <= 1'b0;
			whigh_reg <= 1'b0;
			low_reg <= '0;
			high_reg <= '0;
		end else if (div_done) begin
			valid_reg <= 1'b1;
			wlow_reg <= div_wr_reg; // RL22
			whigh_reg <= 1'b0;
			low_reg <= div_quotient; // RL23
			high_reg <= '0;
		end else begin
			valid_reg <= single_take;
			wlow_reg <= single_take && cond_pass; // RL22
			whigh_reg <= single_take && cond_pass && sel_two;
			low_reg <= sel_low;
			high_reg <= sel_high;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sat_reg <= SAT_FLAG_RESET;
		end else begin
			sat_reg <= sat_next; // RL13 RL14
		end
	end

	// Data follows the selected op every cycle; only result_valid marks a new result
	// No N/Z/C/V outputs exist, so those flags are never disturbed
	assign result_valid = valid_reg; // RL5
	assign write_low = wlow_reg;
	assign write_high = whigh_reg;
	assign result_low = low_reg;
	assign result_high = high_reg;
	assign saturation_sticky_flag = sat_reg;
endmodule // long_mul_div_saturate_unit

// >>> verification/mds_checker.sv
// Port-level checker for the multiply, divide and saturate datapath.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mds_checker
	import mds_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire logic [4:0] op_code,
	input wire logic cond_pass,
	input wire logic status_write,
	input wire logic status_write_sat,
	input wire logic result_valid,
	input wire logic write_low,
	input wire logic write_high,
	input wire logic saturation_sticky_flag
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	wire logic take = issue_valid && issue_ready;
	wire logic div_op = op_code == OP_SIGNED_DIVIDE || op_code == OP_UNSIGNED_DIVIDE;
	wire logic mul_op = op_code <= OP_SMUL_ACC;
	wire logic lane_op = op_code >= OP_SADD_H;
	wire logic flag = saturation_sticky_flag;
	a_quick_answer: assert property (take && !div_op |=> result_valid)
		else $error("no result one cycle after take");
	a_div_answer: assert property (take && div_op |-> ##35 result_valid)
		else $error("divide result not at cycle 35");
	a_div_stall: assert property (take && div_op |=> (!issue_ready && !result_valid) [*8])
		else $error("divide not stalling the issuer");
	a_mul_writes: assert property (take && mul_op && cond_pass |=> write_low && write_high)
		else $error("long multiply must write both halves");
	a_div_writes: assert property (take && div_op && cond_pass |-> ##35 write_low && !write_high)
		else $error("divide write enables wrong");
	a_cond_false: assert property (take && !cond_pass && !status_write |=>
		!write_low && !write_high && flag == $past(flag))
		else $error("failed condition still wrote");
	a_flag_hold: assert property (flag && !status_write |=> flag)
		else $error("sticky flag cleared without status write");
	a_flag_write: assert property (status_write && !issue_valid |=>
		flag == $past(status_write_sat))
		else $error("status write did not land in flag");
	a_lane_flag: assert property (take && lane_op && !flag && !status_write |=> !flag)
		else $error("narrow lane op set the flag");
	a_div_flag: assert property (take && div_op && !status_write |=> flag == $past(flag))
		else $error("divide changed the flag");
endmodule // mds_checker

bind long_mul_div_saturate_unit mds_checker u_chk (.sys_clk, .rst, .issue_valid, .issue_ready,
	.op_code, .cond_pass, .status_write, .status_write_sat, .result_valid, .write_low,
	.write_high, .saturation_sticky_flag);

// >>> verification/pipe_issuer.sv
// Pipeline issuer model: sends queued ops, keeps the result register pair.
// Assumes the bench fills pend; one entry leaves at each take edge.
`timescale 1ns/10ps
module pipe_issuer
	import mds_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic issue_ready,
	input wire logic write_high,
	input wire logic [DATA_W-1:0] result_low,
	input wire logic [DATA_W-1:0] result_high,
	output logic issue_valid,
	output logic [4:0] op_code,
	output logic cond_pass,
	output logic [DATA_W-1:0] first_operand,
	output logic [DATA_W-1:0] second_operand,
	output logic [DATA_W-1:0] acc_low,
	output logic [DATA_W-1:0] acc_high,
	output logic [5:0] sat_position,
	output logic [1:0] shift_kind,
	output logic [4:0] shift_amount
);
	logic [82:0] pend[$];
	logic rdy;
	logic [DATA_W-1:0] lo_reg;
	logic [DATA_W-1:0] hi_reg;
	// Forwarded so a back-to-back accumulate sees the fresh pair
	assign acc_low = write_high ? result_low : lo_reg;
	assign acc_high = write_high ? result_high : hi_reg;
	initial begin
		issue_valid = 1'b0;
		{op_code, cond_pass, first_operand, second_operand} = '0;
		{sat_position, shift_kind, shift_amount} = '0;
	end
	always @(negedge sys_clk) rdy <= issue_ready;
	always @(posedge sys_clk) begin
		lo_reg <= rst ? '0 : acc_low;
		hi_reg <= rst ? '0 : acc_high;
		if (issue_valid && rdy)
			void'(pend.pop_front());
		#1;
		issue_valid <= pend.size() > 0;
		if (pend.size() > 0)
			{op_code, cond_pass, first_operand, second_operand, sat_position, shift_kind,
				shift_amount} <= pend[0];
	end
endmodule // pipe_issuer

// >>> verification/testbench.sv
// Self-checking bench: reference model against the datapath at each result.
// Assumes the issuer model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module testbench
	import mds_pkg::*;
;
	logic sys_clk, rst, status_write, status_write_sat, issue_valid, issue_ready, cond_pass;
	logic result_valid, write_low, write_high, saturation_sticky_flag;
	logic [4:0] op_code;
	logic [4:0] shift_amount;
	logic [5:0] sat_position;
	logic [1:0] shift_kind;
	logic [DATA_W-1:0] first_operand, second_operand, acc_low, acc_high, result_low, result_high;
	int err_count = 0;
	int tests_run = 0;
	int seed = 32'he5e5;
	logic [66:0] exp_q[$];
	logic [66:0] e;
	logic [63:0] acc_m = '0;
	logic flag_m = SAT_FLAG_RESET;

	long_mul_div_saturate_unit u_dut (.sys_clk, .rst, .issue_valid, .issue_ready, .op_code,
		.cond_pass, .first_operand, .second_operand, .acc_low, .acc_high, .sat_position,
		.shift_kind, .shift_amount, .status_write, .status_write_sat, .result_valid,
		.write_low, .write_high, .result_low, .result_high, .saturation_sticky_flag);
	pipe_issuer u_pipe (.sys_clk, .rst, .issue_ready, .write_high, .result_low, .result_high,
		.issue_valid, .op_code, .cond_pass, .first_operand, .second_operand, .acc_low,
		.acc_high, .sat_position, .shift_kind, .shift_amount);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			err_count++;
			$display("MISMATCH t=%0t data %h exp %h", $time, got, want);
		end
	endtask
	task automatic chk1(input logic got, input logic want);
		tests_run++;
		if (got !== want) begin
			err_count++;
			$display("MISMATCH t=%0t bit %b exp %b", $time, got, want);
		end
	endtask

	function automatic longint sx(logic [31:0] x, int w);
		sx = longint'(x) << (64 - w);
		sx = sx >>> (64 - w);
	endfunction
	function automatic longint clampv(longint v, bit u, int n, inout bit s);
		longint hi;
		longint lo;
		hi = u ? (longint'(1) << n) - 1 : (longint'(1) << (n - 1)) - 1;
		lo = u ? 0 : -hi - 1;
		clampv = v < lo ? lo : (v > hi ? hi : v);
		s = s | (clampv != v);
	endfunction

	task automatic issue(input logic [4:0] op, input logic c, input logic [31:0] a,
		input logic [31:0] b, input logic [5:0] n, input logic [1:0] sk, input logic [4:0] sa);
		logic [63:0] p;
		logic [31:0] lo;
		logic [31:0] x;
		longint r;
		int w;
		bit s;
		bit t;
		s = 0;
		p = 'x;
		if (op <= OP_SMUL_ACC) begin
			p = (op[1] ? {{32{a[31]}}, a} : {32'h0, a}) * (op[1] ? {{32{b[31]}}, b} : {32'h0, b});
			p = p + (op[0] ? acc_m : 64'h0);
			if (c)
				acc_m = p;
			lo = p[31:0];
		end else if (op <= OP_UNSIGNED_DIVIDE) begin
			lo = a / b;
			if (op == OP_SIGNED_DIVIDE)
				lo = $signed(a) / $signed(b);
			if (b == 0)
				lo = 32'h0;
		end else if (op <= OP_UCLAMP) begin
			x = a;
			if (sk == SHIFT_LSL)
				x = a << sa;
			if (sk == SHIFT_ASR)
				x = $signed(a) >>> sa;
			lo = 32'(clampv(sx(x, 32), op[0], n, s));
		end else if (op <= OP_UCLAMP_H) begin
			lo[31:16] = 16'(clampv(sx(a >> 16, 16), op[0], n, s));
			lo[15:0] = 16'(clampv(sx(a, 16), op[0], n, s));
		end else begin
			w = op <= OP_SSUB ? 32 : (op <= OP_SSUB_H ? 16 : 8);
			lo = 32'h0;
			t = 0;
			for (int i = 0; i < 32 / w; i++) begin
				r = sx(a >> (i * w), w) + (op[0] ? -sx(b >> (i * w), w) : sx(b >> (i * w), w));
				r = clampv(r, 0, w, t);
				lo = lo | ((32'(r) & (32'hffffffff >> (32 - w))) << (i * w));
			end
			// Only the full-word form reaches the sticky flag
			if (w == 32)
				s = t;
		end
		if (c)
			flag_m = flag_m | s;
		exp_q.push_back({c, c && op <= OP_SMUL_ACC, flag_m, p[63:32], lo});
		u_pipe.pend.push_back({op, c, a, b, n, sk, sa});
	endtask

	always @(posedge sys_clk) begin
		#2;
		if (result_valid === 1'b1) begin
			e = exp_q.pop_front();
			chk1(write_low, e[66]);
			chk1(write_high, e[65]);
			chk1(saturation_sticky_flag, e[64]);
			if (e[66])
				chk32(result_low, e[31:0]);
			if (e[65])
				chk32(result_high, e[63:32]);
		end
	end

	task automatic drain();
		int k;
		k = 0;
		while ((u_pipe.pend.size() > 0 || exp_q.size() > 0) && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
		chk1(k < 2000, 1'b1);
	endtask
	task automatic stat_wr(input logic v);
		drain();
		@(posedge sys_clk);
		#1;
		status_write = 1'b1;
		status_write_sat = v;
		@(posedge sys_clk);
		#1;
		status_write = 1'b0;
		status_write_sat = ~v;
		flag_m = v;
		#2;
		chk1(saturation_sticky_flag, v);
	endtask
	task automatic rnd_op();
		logic [4:0] op;
		logic [5:0] n;
		logic [1:0] sk;
		logic [4:0] sa;
		op = 5'($unsigned($random(seed)) % 16);
		sk = 2'($unsigned($random(seed)) % 3);
		sa = 5'($random(seed));
		n = 6'($unsigned($random(seed)) % 32);
		if (sk == SHIFT_ASR && sa == 0)
			sa = 5'h1;
		if (op == OP_SCLAMP)
			n = n + 6'h1;
		if (op == OP_SCLAMP_H)
			n = n % 16 + 6'h1;
		if (op == OP_UCLAMP_H)
			n = n % 16;
		issue(op, $random(seed) % 8 != 0, $random(seed), $random(seed), n, sk, sa);
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		rst = 1'b1;
		status_write = 1'b0;
		status_write_sat = 1'b0;
		repeat (12) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk1(issue_ready, 1'b1);
		chk1(saturation_sticky_flag, SAT_FLAG_RESET);
		issue(OP_UMUL_LONG, 1, 32'hffffffff, 32'hffffffff, 0, 0, 0);
		issue(OP_UMUL_ACC, 1, 32'hffffffff, 32'h2, 0, 0, 0);
		issue(OP_SMUL_LONG, 1, 32'h80000000, 32'h7fffffff, 0, 0, 0);
		issue(OP_SMUL_ACC, 1, 32'hfffffff9, 32'h3, 0, 0, 0);
		issue(OP_SIGNED_DIVIDE, 1, 32'hfffffff9, 32'h2, 0, 0, 0);
		issue(OP_UNSIGNED_DIVIDE, 1, 32'h7, 32'h0, 0, 0, 0);
		issue(OP_SIGNED_DIVIDE, 0, 32'h9, 32'h2, 0, 0, 0);
		issue(OP_SADD_B, 1, 32'h7f7f7f7f, 32'h01010101, 0, 0, 0);
		issue(OP_SSUB_H, 1, 32'h80008000, 32'h00010001, 0, 0, 0);
		issue(OP_SCLAMP, 0, 32'h7fffffff, 0, 1, SHIFT_NONE, 0);
		issue(OP_UCLAMP, 1, 32'hffffff00, 0, 8, SHIFT_ASR, 31);
		stat_wr(1'b0);
		for (int j = 0; j < 400; j++) begin
			rnd_op();
			if (j % 50 == 49)
				stat_wr(1'($random(seed)));
		end
		drain();
		finish_test();
	end
endmodule // testbench
